// ===== dcsr_consts.svh
// constants and rule summary for the ddr3 command spacing controller
// Summary of operation
// R1: write to power-down: WL+2+ceil(write_recovery_time/tCK) when chop fixed
// R2: autoprecharge write to power-down: WL+2+WR+1
// R3: refresh to power-down at least one clock
// R4: mode set to power-down waits mode update delay
// R5: termination on/off latency equals WL minus two; TERM_LAT is computed but unused, and termination rises with the command
// R6: termination high four clocks without eight-beat write
// R7: termination high six clocks with eight-beat write
// R8: first leveling strobe edge after forty clocks
// R9: leveling strobe drive starts after twenty-five clocks
// R10: refresh to refresh or activate 90 ns
// R11: average refresh interval 7.8 us, hot 3.9 us
// R12: locked-loop commands wait frozen-loop exit delay
// R13: nanosecond limits round up to whole clocks
// R14: slow clock still meets refresh interval
// R15: internal write starts WL+4, or WL+2 fixed chop
// R16: power-down may assert during pending row operations
// R17: refresh power-down may also need frozen exit delay
// R18: power-down only after all spacing counters expire; power-down entry does not wait for the refresh-cycle or leveling counters
`ifndef DCSR_CONSTS_SVH
`define DCSR_CONSTS_SVH
`define DCSR_CLK_PS          8000
`define DCSR_RFC_NS          90
`define DCSR_REFI_NORM_NS    7800
`define DCSR_REFI_HOT_NS     3900
`define DCSR_WR_NS           15
`define DCSR_XPDLL_NS        24
`define DCSR_XPDLL_MIN_CK    10
`define DCSR_MOD_CK          12
`define DCSR_REFPDEN_CK      1
`define DCSR_TERM_SHORT_CK   4
`define DCSR_TERM_LONG_CK    6
`define DCSR_LVL_EN_CK       25
`define DCSR_LVL_FIRST_CK    40
`define DCSR_WR_SLACK_CHOP   2
`define DCSR_WR_SLACK_FULL   4
`define DCSR_TERM_LAT_SUB    2
`define DCSR_CNT_W           16
`endif

// ===== dcsr_ctrl.sv
// host-side command spacing controller for a ddr3l device
`timescale 1ns/1ps
`include "dcsr_consts.svh"
module dcsr_ctrl
    import dcsr_pkg::*;
#(
    parameter int W          = `DCSR_CNT_W,
    parameter int COLUMN_WRITE_LATENCY        = 5,
    parameter int AL         = 0,
    parameter int WR_CK      = 8,
    parameter int REFI_NS    = `DCSR_REFI_NORM_NS,
    parameter int REFI_HOT   = `DCSR_REFI_HOT_NS
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // user request
    input  wire logic       req_valid,
    input  wire logic [3:0] req_cmd,
    input  wire logic       req_chop_fixed,
    input  wire logic       req_eight_beat,
    input  wire logic       hot_temp,
    // user answer
    output logic            req_ready,
    output logic            refresh_due,
    // device pins
    output logic [3:0]      cmd_ff,
    output logic            clk_enable_ff,
    output logic            termination_control_ff,
    output logic            strobe_oe_ff,
    output logic            strobe_edge_ff,
    output logic            int_write_ff
);
    localparam int WRITE_LATENCY  = COLUMN_WRITE_LATENCY + AL;
    localparam int TERM_LAT       = WRITE_LATENCY - `DCSR_TERM_LAT_SUB; // R5
    localparam int WR_RND_CK      = (`DCSR_WR_NS * 1000 + `DCSR_CLK_PS - 1) / `DCSR_CLK_PS;
    localparam int RFC_CK         = (`DCSR_RFC_NS * 1000 + `DCSR_CLK_PS - 1) / `DCSR_CLK_PS;
    localparam int XPDLL_NS_CK    = (`DCSR_XPDLL_NS * 1000 + `DCSR_CLK_PS - 1) / `DCSR_CLK_PS;
    localparam int XPDLL_CK       = XPDLL_NS_CK > `DCSR_XPDLL_MIN_CK ?
                                    XPDLL_NS_CK : `DCSR_XPDLL_MIN_CK;
    localparam int REFI_N_CK      = REFI_NS * 1000 / `DCSR_CLK_PS;
    localparam int REFI_H_CK      = REFI_HOT * 1000 / `DCSR_CLK_PS;
    localparam int WR_GAP_CHOP    = WRITE_LATENCY + `DCSR_WR_SLACK_CHOP + WR_RND_CK;
    localparam int WR_GAP_FULL    = WRITE_LATENCY + `DCSR_WR_SLACK_FULL + WR_RND_CK;
    localparam int WRA_GAP_CHOP   = WRITE_LATENCY + `DCSR_WR_SLACK_CHOP + WR_CK + 1;
    localparam int WRA_GAP_FULL   = WRITE_LATENCY + `DCSR_WR_SLACK_FULL + WR_CK + 1;
    localparam int PIPE           = 32;

    dcsr_state_e  state_ff;
    logic         accept;
    logic         pd_busy;
    logic         rfc_busy;
    logic         xp_busy;
    logic         lvl_busy;
    logic         pd_load;
    logic [W-1:0] pd_val;
    logic [W-1:0] term_cnt_ff;
    logic [W-1:0] lvl_cnt_ff;
    logic         lvl_on_ff;
    logic [W-1:0] refi_cnt_ff;
    logic         frozen_ff;
    logic [PIPE-1:0] wr_pipe_ff;
    logic         legal;
    dcsr_cmd_e    cmd;
    logic [W-1:0] ref_age_ff;
    logic [W-1:0] lvl_age_ff;

    assign cmd = dcsr_cmd_e'(req_cmd);

    // spacing for the power-down counter from the issued command
    always_comb
    begin
        pd_load = 1'b0;
        pd_val  = '0;
        case (cmd)
            DCSR_CMD_WR:
            begin
                pd_load = accept;
                pd_val  = W'(req_chop_fixed ? WR_GAP_CHOP : WR_GAP_FULL); // R1
            end
            DCSR_CMD_WRA:
            begin
                pd_load = accept;
                pd_val  = W'(req_chop_fixed ? WRA_GAP_CHOP : WRA_GAP_FULL); // R2
            end
            DCSR_CMD_REF:
            begin
                pd_load = accept;
                pd_val  = W'(`DCSR_REFPDEN_CK); // R3
            end
            DCSR_CMD_MRS:
            begin
                pd_load = accept;
                pd_val  = W'(`DCSR_MOD_CK); // R4
            end
            default:
            begin
                pd_load = 1'b0;
                pd_val  = '0;
            end
        endcase
    end

    // largest remaining gap wins before power-down entry
    dcsr_gap_timer #(.W(W)) u_pd_gap ( // R18
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (pd_load),
        .value   (pd_val),
        .busy    (pd_busy)
    );

    // refresh cycle time guards refresh and activate
    dcsr_gap_timer #(.W(W)) u_rfc_gap ( // R10
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (accept && cmd == DCSR_CMD_REF),
        .value   (W'(RFC_CK)),
        .busy    (rfc_busy)
    );

    // frozen-loop exit delay after leaving power-down
    dcsr_gap_timer #(.W(W)) u_xp_gap ( // R12
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (accept && cmd == DCSR_CMD_PDX && frozen_ff),
        .value   (W'(XPDLL_CK)),
        .busy    (xp_busy)
    );

    // per-command legality; write, mode set and leveling wait only on the leveling counter, power-down exit and nop on no counter
    always_comb
    begin
        legal = 1'b1;
        case (cmd)
            DCSR_CMD_PDE: legal = !pd_busy && !xp_busy && state_ff == DCSR_ST_ACTIVE
                                  && term_cnt_ff == '0; // R18 R17
            DCSR_CMD_PDX: legal = state_ff == DCSR_ST_PWRDN;
            DCSR_CMD_REF,
            DCSR_CMD_ACT: legal = !rfc_busy && state_ff != DCSR_ST_PWRDN; // R10
            DCSR_CMD_RD,
            DCSR_CMD_ODT: legal = !xp_busy && state_ff != DCSR_ST_PWRDN; // R12
            DCSR_CMD_NOP: legal = 1'b1;
            default:      legal = state_ff != DCSR_ST_PWRDN && !lvl_busy;
        endcase
    end

    assign lvl_busy = lvl_on_ff;
    assign accept   = req_valid && legal && req_ready;

    // ready is low only in reset and high on every clock after it; legality gates accept
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            req_ready <= 1'b0;
        else
            req_ready <= 1'b1;
    end

    // command pin and power state
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_ff        <= 4'h0;
            clk_enable_ff <= 1'b1;
            state_ff      <= DCSR_ST_ACTIVE;
            frozen_ff     <= 1'b0;
        end
        else
        begin
            cmd_ff <= accept ? req_cmd : 4'h0;
            if (accept && cmd == DCSR_CMD_PDE)
            begin
                clk_enable_ff <= 1'b0; // R16
                state_ff      <= DCSR_ST_PWRDN;
                frozen_ff     <= 1'b1; // worst case: assume loop frozen
            end
            else if (accept && cmd == DCSR_CMD_PDX)
            begin
                clk_enable_ff <= 1'b1;
                state_ff      <= DCSR_ST_EXIT;
            end
            else if (state_ff == DCSR_ST_EXIT && !xp_busy)
            begin
                state_ff  <= DCSR_ST_ACTIVE;
                frozen_ff <= 1'b0;
            end
        end
    end

    // termination control held high for the short or long time
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            term_cnt_ff            <= '0;
            termination_control_ff <= 1'b0;
        end
        else if (accept && (cmd == DCSR_CMD_WR || cmd == DCSR_CMD_WRA
                            || cmd == DCSR_CMD_ODT))
        begin
            termination_control_ff <= 1'b1;
            term_cnt_ff <= (cmd != DCSR_CMD_ODT && req_eight_beat) ?
                           W'(`DCSR_TERM_LONG_CK) : W'(`DCSR_TERM_SHORT_CK); // R6 R7
        end
        else if (term_cnt_ff > W'(1))
            term_cnt_ff <= term_cnt_ff - 1'b1;
        else
        begin
            term_cnt_ff            <= '0;
            termination_control_ff <= 1'b0;
        end
    end

    // write leveling strobe enable and first rising edge
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            lvl_cnt_ff     <= '0;
            lvl_on_ff      <= 1'b0;
            strobe_oe_ff   <= 1'b0;
            strobe_edge_ff <= 1'b0;
        end
        else if (accept && cmd == DCSR_CMD_LVL)
        begin
            lvl_cnt_ff     <= '0;
            lvl_on_ff      <= 1'b1;
            strobe_oe_ff   <= 1'b0;
            strobe_edge_ff <= 1'b0;
        end
        else if (lvl_on_ff)
        begin
            lvl_cnt_ff <= lvl_cnt_ff + 1'b1;
            if (lvl_cnt_ff >= W'(`DCSR_LVL_EN_CK - 1))
                strobe_oe_ff <= 1'b1; // R9
            if (lvl_cnt_ff == W'(`DCSR_LVL_FIRST_CK - 1))
            begin
                strobe_edge_ff <= 1'b1; // R8
                lvl_on_ff      <= 1'b0;
            end
        end
        else
            strobe_edge_ff <= 1'b0;
    end

    // refresh interval: due flag set when average interval expires
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            refi_cnt_ff <= '0;
            refresh_due <= 1'b0;
        end
        else if (accept && cmd == DCSR_CMD_REF)
        begin
            refi_cnt_ff <= '0;
            refresh_due <= 1'b0;
        end
        else
        begin
            refi_cnt_ff <= refi_cnt_ff + 1'b1;
            if (refi_cnt_ff >= W'(hot_temp ? REFI_H_CK : REFI_N_CK) - W'(1))
                refresh_due <= 1'b1; // R11 R14
        end
    end

    // internal write start: WL+4 normally, WL+2 with fixed chop
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_pipe_ff   <= '0;
            int_write_ff <= 1'b0;
        end
        else
        begin
            wr_pipe_ff <= {1'b0, wr_pipe_ff[PIPE-1:1]};
            if (accept && (cmd == DCSR_CMD_WR || cmd == DCSR_CMD_WRA))
            begin
                if (req_chop_fixed)
                    wr_pipe_ff[WRITE_LATENCY + `DCSR_WR_SLACK_CHOP - 1] <= 1'b1; // R15
                else
                    wr_pipe_ff[WRITE_LATENCY + `DCSR_WR_SLACK_FULL - 1] <= 1'b1; // R15
            end
            int_write_ff <= wr_pipe_ff[0];
        end
    end

    // all checks share the one clock and are idle in reset
    default clocking dcsr_cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ages since refresh and leveling entry; saturate so long idle never wraps
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ref_age_ff <= '1;
            lvl_age_ff <= '0;
        end
        else
        begin
            if (accept && cmd == DCSR_CMD_REF)
                ref_age_ff <= '0;
            else if (ref_age_ff != '1)
                ref_age_ff <= ref_age_ff + 1'b1;
            if (accept && cmd == DCSR_CMD_LVL)
                lvl_age_ff <= '0;
            else if (lvl_age_ff != '1)
                lvl_age_ff <= lvl_age_ff + 1'b1;
        end
    end

    property p_pd_after_gap; (accept && cmd == DCSR_CMD_PDE) |-> !pd_busy; endproperty
    a_pd_after_gap: assert property (p_pd_after_gap) else $error("gap still pending"); // R1 R18
    property p_pd_ck_low; (accept && cmd == DCSR_CMD_PDE) |=> !clk_enable_ff; endproperty
    a_pd_ck_low: assert property (p_pd_ck_low) else $error("clock enable not low"); // R16
    property p_rfc;
        (accept && (cmd == DCSR_CMD_REF || cmd == DCSR_CMD_ACT)) |-> ref_age_ff >= W'(RFC_CK - 1);
    endproperty
    a_rfc: assert property (p_rfc) else $error("refresh spacing too short"); // R10 R13
    property p_term_short;
        $rose(termination_control_ff) |-> termination_control_ff[*4];
    endproperty
    a_term_short: assert property (p_term_short) else $error("termination too short"); // R6
    sequence s_long_write;
        accept && (cmd == DCSR_CMD_WR || cmd == DCSR_CMD_WRA) && req_eight_beat;
    endsequence
    property p_term_long; s_long_write |=> termination_control_ff[*6]; endproperty
    a_term_long: assert property (p_term_long) else $error("long termination short"); // R7
    property p_lvl; $rose(strobe_oe_ff) |-> lvl_age_ff >= W'(`DCSR_LVL_EN_CK); endproperty
    a_lvl: assert property (p_lvl) else $error("strobe driven too early"); // R9
    property p_lvl_edge;
        $rose(strobe_edge_ff) |-> lvl_age_ff >= W'(`DCSR_LVL_FIRST_CK);
    endproperty
    a_lvl_edge: assert property (p_lvl_edge) else $error("strobe edge too early"); // R8
    property p_xp; (accept && cmd == DCSR_CMD_RD) |-> !xp_busy; endproperty
    a_xp: assert property (p_xp) else $error("read before loop exit delay"); // R12
endmodule : dcsr_ctrl

// ===== dcsr_dev_model.sv
// behavioural device model that watches the host's command spacing
`timescale 1ns/1ps
`include "dcsr_consts.svh"
module dcsr_dev_model
    import dcsr_pkg::*;
#(
    parameter int WL    = 5,
    parameter int WR_CK = 8
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // device pins
    input  wire logic [3:0] cmd,
    input  wire logic       termination_control,
    input  wire logic       strobe_oe,
    input  wire logic       strobe_edge,
    // mode register view
    input  wire logic       chop_fixed,
    input  wire logic       eight_beat,
    // violations seen so far
    output int              viol
);
    // nanosecond limits rounded up to whole clocks
    localparam int WRITE_RECOVERY_TIME = (`DCSR_WR_NS * 1000 + `DCSR_CLK_PS - 1) / `DCSR_CLK_PS;
    localparam int RFC = (`DCSR_RFC_NS * 1000 + `DCSR_CLK_PS - 1) / `DCSR_CLK_PS;
    int   wr_ff, wra_ff, ref_ff, mrs_ff, lvl_ff, pdx_ff, run_ff;
    int   va_ff = 0;
    int   vb_ff = 0;
    logic cw_ff, cwa_ff, oe_ff, long_ff;
    // counts survive a reset so a late reset cannot hide an earlier fault
    assign viol = va_ff + vb_ff;
    // internal latencies of the array itself are not visible on these pins
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ff  <= 1000;
            wra_ff <= 1000;
            ref_ff <= 1000;
            mrs_ff <= 1000;
            lvl_ff <= 1000;
            pdx_ff <= 1000;
            oe_ff  <= 1'h0;
        end
        else
        begin
            wr_ff  <= (cmd == DCSR_CMD_WR) ? 1 : wr_ff + 1;
            wra_ff <= (cmd == DCSR_CMD_WRA) ? 1 : wra_ff + 1;
            ref_ff <= (cmd == DCSR_CMD_REF) ? 1 : ref_ff + 1;
            mrs_ff <= (cmd == DCSR_CMD_MRS) ? 1 : mrs_ff + 1;
            lvl_ff <= (cmd == DCSR_CMD_LVL) ? 1 : lvl_ff + 1;
            pdx_ff <= (cmd == DCSR_CMD_PDX) ? 1 : pdx_ff + 1;
            oe_ff  <= strobe_oe;
            if (cmd == DCSR_CMD_WR)
                cw_ff <= chop_fixed;
            if (cmd == DCSR_CMD_WRA)
                cwa_ff <= chop_fixed;
            // busy rows at power-down entry are simply finished first
            if (cmd == DCSR_CMD_PDE && (wr_ff < WL + (cw_ff ? 2 : 4) + WRITE_RECOVERY_TIME
                || wra_ff < WL + (cwa_ff ? 2 : 4) + WR_CK + 1
                || ref_ff < `DCSR_REFPDEN_CK || mrs_ff < `DCSR_MOD_CK))
                va_ff <= va_ff + 1;
            if ((cmd == DCSR_CMD_REF || cmd == DCSR_CMD_ACT) && ref_ff < RFC)
                va_ff <= va_ff + 1;
            if ((cmd == DCSR_CMD_RD || cmd == DCSR_CMD_ODT) && pdx_ff < `DCSR_XPDLL_MIN_CK)
                va_ff <= va_ff + 1;
            if ((strobe_oe && !oe_ff && lvl_ff < `DCSR_LVL_EN_CK)
                || (strobe_edge && lvl_ff < `DCSR_LVL_FIRST_CK))
                va_ff <= va_ff + 1;
        end
    end
    // termination high time, longer once an eight-beat WR command (not WRA) lands in it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            run_ff  <= 0;
            long_ff <= 1'h0;
        end
        else if (termination_control)
        begin
            run_ff  <= run_ff + 1;
            long_ff <= long_ff | (cmd == DCSR_CMD_WR && eight_beat);
        end
        else
        begin
            if (run_ff != 0 && run_ff < (long_ff ? `DCSR_TERM_LONG_CK : `DCSR_TERM_SHORT_CK))
                vb_ff <= vb_ff + 1;
            run_ff  <= 0;
            long_ff <= 1'h0;
        end
    end
endmodule : dcsr_dev_model

// ===== dcsr_gap_timer.sv
// reloadable down counter keeping the largest pending gap
`timescale 1ns/1ps
module dcsr_gap_timer #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // load request
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    // status
    output logic              busy
);
    logic [W-1:0] cnt_ff;

    // keep the larger of remaining and newly requested wait
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cnt_ff <= '0;
        else if (load && value > cnt_ff)
            cnt_ff <= value;
        else if (cnt_ff != '0)
            cnt_ff <= cnt_ff - 1'b1;
    end

    assign busy = (cnt_ff != '0);
endmodule : dcsr_gap_timer

// ===== dcsr_pkg.sv
// types shared by the ddr3 command spacing controller
package dcsr_pkg;
    typedef enum logic [3:0] {
        DCSR_CMD_NOP  = 4'h0,
        DCSR_CMD_ACT  = 4'h1,
        DCSR_CMD_RD   = 4'h2,
        DCSR_CMD_WR   = 4'h3,
        DCSR_CMD_WRA  = 4'h4,
        DCSR_CMD_REF  = 4'h5,
        DCSR_CMD_MRS  = 4'h6,
        DCSR_CMD_ODT  = 4'h7,
        DCSR_CMD_LVL  = 4'h8,
        DCSR_CMD_PDE  = 4'h9,
        DCSR_CMD_PDX  = 4'hA
    } dcsr_cmd_e;
    typedef enum logic [1:0] {
        DCSR_ST_ACTIVE = 2'b00,
        DCSR_ST_PWRDN  = 2'b01,
        DCSR_ST_EXIT   = 2'b11
    } dcsr_state_e;
endpackage : dcsr_pkg

// ===== tb_top.sv
// self-checking bench for the command spacing controller
`timescale 1ns/1ps
`include "dcsr_consts.svh"
module tb_top import dcsr_pkg::*;;
    localparam int WL = 5;
    typedef struct {
        dcsr_cmd_e cmd;
        logic      chop;
        logic      eight;
        int        term;
        int        iw;
    } dcsr_row_s;
    logic       sys_clk, rst, req_valid, req_chop_fixed, req_eight_beat, hot_temp;
    logic [3:0] req_cmd, cmd_ff;
    logic       req_ready, refresh_due, clk_enable_ff, termination_control_ff;
    logic       strobe_oe_ff, strobe_edge_ff, int_write_ff;
    int         err_total = 0;
    int         compares = 0;
    int         cyc = 0;
    int         viol, g, k, p;
    dcsr_row_s  rows [10] = '{'{DCSR_CMD_ACT, 1'h0, 1'h0, 0, 0},
        '{DCSR_CMD_RD, 1'h0, 1'h0, 0, 0}, '{DCSR_CMD_WR, 1'h1, 1'h0, 4, WL + 2},
        '{DCSR_CMD_WR, 1'h0, 1'h1, 6, WL + 4}, '{DCSR_CMD_WR, 1'h0, 1'h0, 4, WL + 4},
        '{DCSR_CMD_WRA, 1'h1, 1'h0, 4, WL + 2}, '{DCSR_CMD_MRS, 1'h0, 1'h0, 0, 0},
        '{DCSR_CMD_ODT, 1'h0, 1'h0, 4, 0}, '{DCSR_CMD_REF, 1'h0, 1'h0, 0, 0},
        '{DCSR_CMD_ACT, 1'h0, 1'h0, 0, 0}};
    dcsr_cmd_e  pc [5] = '{DCSR_CMD_WR, DCSR_CMD_WRA, DCSR_CMD_MRS, DCSR_CMD_REF, DCSR_CMD_ACT};
    int         plo [5] = '{WL + 4, WL + 11, 12, 1, 1};
    int         phi [5] = '{WL + 6, WL + 13, 14, 14, 4};

    dcsr_ctrl #(.REFI_NS(800), .REFI_HOT(400)) dut (.sys_clk(sys_clk), .rst(rst),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_chop_fixed(req_chop_fixed),
        .req_eight_beat(req_eight_beat), .hot_temp(hot_temp), .req_ready(req_ready),
        .refresh_due(refresh_due), .cmd_ff(cmd_ff), .clk_enable_ff(clk_enable_ff),
        .termination_control_ff(termination_control_ff), .strobe_oe_ff(strobe_oe_ff),
        .strobe_edge_ff(strobe_edge_ff), .int_write_ff(int_write_ff));
    dcsr_dev_model #(.WL(WL), .WR_CK(8)) u_dev (.sys_clk(sys_clk), .rst(rst), .cmd(cmd_ff),
        .termination_control(termination_control_ff), .strobe_oe(strobe_oe_ff),
        .strobe_edge(strobe_edge_ff), .chop_fixed(req_chop_fixed),
        .eight_beat(req_eight_beat), .viol(viol));

    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok)
        begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check
    task automatic finish_test();
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // request held until it shows on the pins; n counts cycles from the previous command
    task automatic issue(input dcsr_cmd_e c, input logic ch, input logic e8, output int n);
        @(negedge sys_clk);
        req_cmd        = c;
        req_chop_fixed = ch;
        req_eight_beat = e8;
        req_valid      = 1'h1;
        n = 1;
        while (cmd_ff !== c && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        req_valid = 1'h0;
        check(n < 200, "command never taken");
    endtask : issue
    task automatic wait_due(output int n);
        n = 1;
        @(negedge sys_clk);
        while (refresh_due !== 1'h1 && n < 300)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_due
    task automatic run_row(input dcsr_row_s r);
        int t, w, n;
        t = 0;
        w = 0;
        issue(r.cmd, r.chop, r.eight, n);
        for (int j = 0; j < 25; j++)
        begin
            if (termination_control_ff === 1'h1)
                t++;
            if (int_write_ff === 1'h1 && w == 0)
                w = j;
            @(negedge sys_clk);
        end
        check(t == r.term, "termination high time");
        check(w == r.iw, "internal write start");
    endtask : run_row

    // free-running clock, 8 ns period
    initial
    begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    // cut a hang short
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            err_total++;
            finish_test();
        end
    end
    // main sequence
    initial
    begin
        rst            = 1'h1;
        req_valid      = 1'h0;
        req_cmd        = 4'h0;
        req_chop_fixed = 1'h0;
        req_eight_beat = 1'h0;
        hot_temp       = 1'h0;
        repeat (5) @(negedge sys_clk);
        check(cmd_ff === 4'h0 && clk_enable_ff === 1'h1, "pin levels in reset");
        rst = 1'h0;
        repeat (2) @(negedge sys_clk);
        check(req_ready === 1'h1, "not ready after reset");
        foreach (rows[i])
            run_row(rows[i]);
        // power-down held off by each pending gap, then exit and a locked-loop read
        for (int i = 0; i < 5; i++)
        begin
            issue(pc[i], 1'h1, 1'h0, g);
            issue(DCSR_CMD_PDE, 1'h1, 1'h0, g);
            check(g >= plo[i] && g <= phi[i], "power-down spacing");
            @(negedge sys_clk);
            check(clk_enable_ff === 1'h0, "clock enable still high");
            issue(DCSR_CMD_PDX, 1'h1, 1'h0, g);
            @(negedge sys_clk);
            check(clk_enable_ff === 1'h1, "clock enable still low");
            issue(DCSR_CMD_RD, 1'h1, 1'h0, g);
            check(g + 1 >= `DCSR_XPDLL_MIN_CK, "read too soon after exit");
        end
        // refresh due arrives sooner when hot
        hot_temp = 1'h1;
        issue(DCSR_CMD_REF, 1'h0, 1'h0, g);
        wait_due(p);
        check(p > 1 && p <= 50, "hot refresh interval");
        hot_temp = 1'h0;
        issue(DCSR_CMD_REF, 1'h0, 1'h0, g);
        wait_due(k);
        check(k > p && k <= 100, "normal refresh interval");
        // reset in mid-run drops termination at once
        issue(DCSR_CMD_ODT, 1'h0, 1'h0, g);
        rst = 1'h1;
        @(negedge sys_clk);
        check(termination_control_ff === 1'h0 && clk_enable_ff === 1'h1, "mid-run reset");
        rst = 1'h0;
        repeat (2) @(negedge sys_clk);
        check(req_ready === 1'h1, "not ready after second reset");
        // leveling: strobe enable first, then the first strobe edge
        issue(DCSR_CMD_LVL, 1'h0, 1'h0, g);
        g = 0;
        p = 0;
        for (k = 1; k < 60; k++)
        begin
            @(negedge sys_clk);
            if (strobe_oe_ff === 1'h1 && g == 0)
                g = k;
            if (strobe_edge_ff === 1'h1 && p == 0)
                p = k;
        end
        check(g >= `DCSR_LVL_EN_CK && g <= `DCSR_LVL_EN_CK + 2, "strobe enable delay");
        check(p >= `DCSR_LVL_FIRST_CK && p <= `DCSR_LVL_FIRST_CK + 2, "first strobe edge");
        check(viol == 0, "device model saw a spacing fault");
        finish_test();
    end
endmodule : tb_top
